// [src/pwgt_pkg.sv]
// per-lane gate timer package: offsets, fields, reset values, timing, types
// assumes a 50 MHz module clock and a byte-wide management register port
package pwgt_pkg;

    // lane geometry: every bank has eight host and eight media lanes
    localparam int NBANK = 4;
    localparam int NLANE = 8;
    localparam int NCH   = NBANK * 2 * NLANE;

    // register offsets
    localparam logic [7:0] ADDR_CAP        = 8'h81;
    localparam logic [7:0] ADDR_FLAG_HOST  = 8'h86;
    localparam logic [7:0] ADDR_FLAG_MEDIA = 8'h87;
    localparam logic [7:0] ADDR_HOST_EN    = 8'hA0;
    localparam logic [7:0] ADDR_MEDIA_EN   = 8'hA8;
    localparam logic [7:0] ADDR_GATE_CTL   = 8'hB1;
    localparam logic [7:0] ADDR_BANK_SEL   = 8'hF0;
    localparam logic [7:0] ADDR_LANE_SEL   = 8'hF1;
    localparam logic [7:0] ADDR_CUR_HI     = 8'hF2;
    localparam logic [7:0] ADDR_CUR_LO     = 8'hF3;
    localparam logic [7:0] ADDR_RES_HI     = 8'hF4;
    localparam logic [7:0] ADDR_RES_LO     = 8'hF5;

    // gating control byte fields
    localparam int GC_SCOPE_BIT   = 7;
    localparam int GC_RESTART_BIT = 5;
    localparam int GC_AUTO_BIT    = 4;
    localparam int GC_LEN_LSB     = 1;
    localparam int GC_UPD_BIT     = 0;

    // capability / configuration byte fields
    localparam int CAP_AUTO_BIT    = 2;
    localparam int CAP_PERLANE_BIT = 3;
    localparam int CAP_RT_BIT      = 4;

    // reset values
    localparam logic [7:0] CAP_RST = 8'h0C;
    localparam logic [7:0] GC_RST  = 8'h00;

    // time base and update periods
    localparam int CLK_HZ      = 50_000_000;
    localparam int BASE_S      = 1;
    localparam int BASE_CYC    = CLK_HZ * BASE_S;
    localparam int UPD_SLOW_S  = 10;

    // gate duration in seconds for each non-zero gate-time code
    function automatic logic [8:0] gate_secs(input logic [2:0] code);
        case (code)
            3'h1:    gate_secs = 9'h001;
            3'h2:    gate_secs = 9'h005;
            3'h3:    gate_secs = 9'h00A;
            3'h4:    gate_secs = 9'h01E;
            3'h5:    gate_secs = 9'h03C;
            3'h6:    gate_secs = 9'h078;
            3'h7:    gate_secs = 9'h12C;
            default: gate_secs = 9'h000;
        endcase
    endfunction

    // per-lane configuration built from a bank's control byte and the capability byte
    typedef struct packed {
        logic [8:0] gate_len;
        logic       auto_rs;
        logic       rt;
    } pwgt_cfg_t;

    // per-lane counts presented to the readout mux
    typedef struct packed {
        logic [15:0] shown;
        logic [15:0] result;
    } pwgt_cnt_t;

    // lane state, one-hot
    typedef enum logic [2:0] {
        L_IDLE = 3'b001,
        L_RUN  = 3'b010,
        L_HELD = 3'b100
    } pwgt_lane_st_t;

endpackage

// [src/pwgt_tick.sv]
// step divider: pulses once every DIV steps
// assumes step is a one-cycle pulse or held high for a free-running divide
module pwgt_tick #(
    parameter int DIV = 2
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // step in, tick out
    input  wire logic step,
    output logic      tick
);
    logic [31:0] cnt_r;
    logic        tick_r;
    wire         wrap = (cnt_r == 32'(DIV - 1));

    // count steps and pulse on wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r  <= 32'h0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= step & wrap;
            if (step) begin
                cnt_r <= wrap ? 32'h0 : cnt_r + 32'h1;
            end
        end
    end

    assign tick = tick_r;
endmodule

// [src/pwgt_lane.sv]
// one lane's gate timer with live, shown and result error counts
// assumes sec_tick and upd_tick are one-cycle pulses on the common time base
module pwgt_lane
    import pwgt_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire pwgt_cfg_t   cfg,
    input  wire logic        en,
    input  wire logic        clr,
    input  wire logic        freeze,
    input  wire logic        sec_tick,
    input  wire logic        upd_tick,
    input  wire logic        err,
    // results
    output pwgt_cnt_t        cnt,
    output logic             done
);
    pwgt_lane_st_t st_r, st_nxt;
    logic [8:0]    timer_r;
    logic [15:0]   live_r, shown_r, result_r;
    logic          done_r;

    // decode of the lane's running and expiry conditions
    wire running = (st_r == L_RUN) & en & ~freeze & (cfg.gate_len != 9'h0);
    wire expire  = running & sec_tick & ((timer_r + 9'h1) == cfg.gate_len);
    wire live_up = running & err & (live_r != 16'hFFFF);

    // next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            L_IDLE:  st_nxt = st_r;
            L_RUN:   st_nxt = (expire && !cfg.auto_rs) ? L_HELD : L_RUN;
            L_HELD:  st_nxt = st_r;
            default: st_nxt = L_IDLE;
        endcase
        if (clr) begin
            st_nxt = L_RUN;
        end
    end

    // state and timer; a clear restarts this lane alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r    <= L_IDLE;
            timer_r <= 9'h0;
            done_r  <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            done_r <= expire & ~clr;
            if (clr || (expire && cfg.auto_rs)) begin
                timer_r <= 9'h0;
            end else if (running && sec_tick && !expire) begin
                timer_r <= timer_r + 9'h1;
            end
        end
    end

    // error counts: live accumulates, shown and result take snapshots
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live_r   <= 16'h0;
            shown_r  <= 16'h0;
            result_r <= 16'h0;
        end else if (clr) begin
            live_r  <= 16'h0;
            shown_r <= 16'h0;
        end else if (expire) begin
            shown_r <= live_r;
            if (cfg.auto_rs) begin
                result_r <= live_r;
                live_r   <= 16'h0;
            end
        end else begin
            if (live_up) begin
                live_r <= live_r + 16'h1;
            end
            if (cfg.rt && upd_tick && running) begin
                shown_r <= live_r;
            end
        end
    end

    assign cnt  = '{shown: shown_r, result: result_r};
    assign done = done_r;

    // checks on the lane's own timer and snapshots
    a_clear_zeroes:
        assert property (@(posedge clk) disable iff (!rst_n)
            clr |=> (timer_r == 9'h0) && (live_r == 16'h0)) else $error("clear missed");
    a_freeze_holds:
        assert property (@(posedge clk) disable iff (!rst_n)
            (freeze && !clr) |=> $stable(timer_r) && $stable(live_r)) else $error("not frozen");
    a_expiry_stops:
        assert property (@(posedge clk) disable iff (!rst_n)
            (expire && !cfg.auto_rs && !clr) |=> (st_r == L_HELD) ##1 $stable(live_r))
            else $error("counter ran past gate");
    a_auto_handoff:
        assert property (@(posedge clk) disable iff (!rst_n)
            (expire && cfg.auto_rs && !clr) |=> (result_r == $past(live_r)) && (timer_r == 9'h0))
            else $error("auto restart hand-off wrong");
    a_quiet_shown:
        assert property (@(posedge clk) disable iff (!rst_n)
            (!cfg.rt && !expire && !clr) |=> $stable(shown_r)) else $error("shown moved");
    a_timer_bound:
        assert property (@(posedge clk) disable iff (!rst_n)
            (st_r == L_RUN) && (cfg.gate_len != 9'h0) && $stable(cfg.gate_len)
            |-> timer_r < cfg.gate_len) else $error("timer overran");
    c_auto_expiry:
        cover property (@(posedge clk) disable iff (!rst_n) expire && cfg.auto_rs);
endmodule

// [src/pwgt_top.sv]
// per-lane pattern-checker gate timers for every host and media lane of all banks
// assumes a byte-wide register port from the management interface, one access a cycle
//
// Function
// - separate gate timer per lane, every bank
// - config bit enables real-time error info
// - expiry raises gating-complete flags
// - unread results overwritten by next expiry
// - lane enable clears timer and counters
// - each lane timer resets independently
// - expiry stops counters, presents period results
// - real-time off: update only at expiry
// - real-time on: refresh at update period
// - gating only when gate-time field nonzero
// - auto-restart bit restarts timers on expiry
// - auto expiry: hand off results, restart
// - result counts implemented for auto-restart
// - restart bit set freezes enabled lanes
// - restart cleared, scope zero: current bank
// - restart cleared, scope one: scoped banks
// - single lane toggle resets only that lane
// - per-lane mode only when mode bit selects
module pwgt_top
    import pwgt_pkg::*;
#(
    parameter int SEC_CYCLES = pwgt_pkg::BASE_CYC
) (
    // clock and reset
    input  wire logic                      CLK,
    input  wire logic                      RST_N,
    // management register port
    input  wire logic [7:0]                REG_ADDR,
    input  wire logic [7:0]                REG_WDATA,
    input  wire logic                      REG_WR,
    input  wire logic                      REG_RD,
    output logic      [7:0]                RD_DATA,
    // pattern checker error events, one per lane
    input  wire logic [pwgt_pkg::NCH-1:0]  ERR_EV
);
    import pwgt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0]     cap_r;
    logic [1:0]     bank_sel_r;
    logic [3:0]     lane_sel_r;
    logic [7:0]     gc_r      [NBANK];
    logic [NBANK-1:0] rst_prev_r;
    logic [NCH-1:0] en_r;
    logic [NCH-1:0] en_prev_r;
    logic [NCH-1:0] flag_r;
    logic [7:0]     rd_data_r;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    wire wr_cap    = REG_WR & (REG_ADDR == ADDR_CAP);
    wire wr_gc     = REG_WR & (REG_ADDR == ADDR_GATE_CTL);
    wire wr_hen    = REG_WR & (REG_ADDR == ADDR_HOST_EN);
    wire wr_men    = REG_WR & (REG_ADDR == ADDR_MEDIA_EN);
    wire wr_bank   = REG_WR & (REG_ADDR == ADDR_BANK_SEL);
    wire wr_lane   = REG_WR & (REG_ADDR == ADDR_LANE_SEL);
    wire rd_fhost  = REG_RD & (REG_ADDR == ADDR_FLAG_HOST);
    wire rd_fmedia = REG_RD & (REG_ADDR == ADDR_FLAG_MEDIA);

    // base index of the selected bank's host and media lanes
    wire [5:0] host_base  = {bank_sel_r, 4'h0};
    wire [5:0] media_base = {bank_sel_r, 4'h8};

    ////////////////////////////////////////////////////////////////////////////
    // mode selection

    wire perlane_mode = cap_r[CAP_PERLANE_BIT];
    wire auto_cap     = cap_r[CAP_AUTO_BIT];
    wire rt_mode      = cap_r[CAP_RT_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // common time base and update period ticks

    logic sec_tick;
    logic slow_tick;

    pwgt_tick #(
        .DIV (SEC_CYCLES)
    ) u_sec (
        .clk   (CLK),
        .rst_n (RST_N),
        .step  (1'b1),
        .tick  (sec_tick)
    );

    pwgt_tick #(
        .DIV (UPD_SLOW_S)
    ) u_slow (
        .clk   (CLK),
        .rst_n (RST_N),
        .step  (sec_tick),
        .tick  (slow_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // capability, selectors and per-bank gating control

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cap_r      <= CAP_RST;
            bank_sel_r <= 2'h0;
            lane_sel_r <= 4'h0;
        end else begin
            if (wr_cap) begin
                cap_r[CAP_PERLANE_BIT] <= REG_WDATA[CAP_PERLANE_BIT];
                cap_r[CAP_RT_BIT]      <= REG_WDATA[CAP_RT_BIT];
            end
            if (wr_bank) begin
                bank_sel_r <= REG_WDATA[1:0];
            end
            if (wr_lane) begin
                lane_sel_r <= REG_WDATA[3:0];
            end
        end
    end

    // gating control byte and restart history, one each per bank
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int b = 0; b < NBANK; b++) begin
                gc_r[b] <= GC_RST;
            end
            rst_prev_r <= '0;
        end else begin
            if (wr_gc) begin
                gc_r[bank_sel_r] <= REG_WDATA;
            end
            for (int b = 0; b < NBANK; b++) begin
                rst_prev_r[b] <= gc_r[b][GC_RESTART_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // restart bit: freeze while set, restart on clear within scope

    logic [NBANK-1:0] rs_set;
    logic [NBANK-1:0] rs_fell;
    logic [NBANK-1:0] scope;
    logic [NBANK-1:0] bank_restart;
    logic [NBANK-1:0] upd_tick;
    pwgt_cfg_t        bank_cfg [NBANK];

    generate
        for (genvar b = 0; b < NBANK; b++) begin : g_bank
            wire [2:0] code  = gc_r[b][GC_LEN_LSB +: 3];
            wire       gated = perlane_mode & (code != 3'h0);
            assign rs_set[b]  = gc_r[b][GC_RESTART_BIT];
            assign rs_fell[b] = rst_prev_r[b] & ~gc_r[b][GC_RESTART_BIT];
            assign scope[b]   = gc_r[b][GC_SCOPE_BIT];
            assign bank_cfg[b] = '{
                gate_len: gated ? gate_secs(code) : 9'h0,
                auto_rs:  auto_cap & gc_r[b][GC_AUTO_BIT],
                rt:       rt_mode};
            // update period picked by the bank's update bit
            assign upd_tick[b] = gc_r[b][GC_UPD_BIT] ? slow_tick : sec_tick;
        end
    endgenerate

    // a scoped clear restarts every scoped bank, an unscoped clear only its own
    wire any_scoped_fell = |(rs_fell & scope);
    assign bank_restart  = (rs_fell & ~scope)
                         | (scope & {NBANK{any_scoped_fell}});

    ////////////////////////////////////////////////////////////////////////////
    // checker enables and enable edges

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            en_r      <= '0;
            en_prev_r <= '0;
        end else begin
            en_prev_r <= en_r;
            if (wr_hen) begin
                en_r[host_base +: NLANE] <= REG_WDATA;
            end
            if (wr_men) begin
                en_r[media_base +: NLANE] <= REG_WDATA;
            end
        end
    end

    // a rising enable clears only that lane; a falling one leaves it holding
    wire [NCH-1:0] en_rise = en_r & ~en_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // lane array: one independent gate timer per lane

    logic [NCH-1:0] lane_clr;
    logic [NCH-1:0] lane_done;
    pwgt_cnt_t      lane_cnt [NCH];

    generate
        for (genvar c = 0; c < NCH; c++) begin : g_lane
            localparam int B = c / (2 * NLANE);
            assign lane_clr[c] = en_rise[c] | (bank_restart[B] & en_r[c]);
            pwgt_lane u_lane (
                .clk      (CLK),
                .rst_n    (RST_N),
                .cfg      (bank_cfg[B]),
                .en       (en_r[c]),
                .clr      (lane_clr[c]),
                .freeze   (rs_set[B]),
                .sec_tick (sec_tick),
                .upd_tick (upd_tick[B]),
                .err      (ERR_EV[c]),
                .cnt      (lane_cnt[c]),
                .done     (lane_done[c])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // gating-complete flags: set on expiry, cleared by reading their byte

    logic [NCH-1:0] flag_clr;

    always_comb begin
        flag_clr = '0;
        if (rd_fhost) begin
            flag_clr[host_base +: NLANE] = {NLANE{1'b1}};
        end
        if (rd_fmedia) begin
            flag_clr[media_base +: NLANE] = {NLANE{1'b1}};
        end
    end

    // an expiry in the clearing cycle wins over the clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            flag_r <= '0;
        end else begin
            flag_r <= (flag_r & ~flag_clr) | lane_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // readout: selected lane's shown and result counts, registers, flags

    wire [5:0]  sel_ch  = {bank_sel_r, lane_sel_r};
    pwgt_cnt_t  sel_cnt;
    assign sel_cnt = lane_cnt[sel_ch];

    logic [7:0] rd_mux;

    always_comb begin
        case (REG_ADDR)
            ADDR_CAP:        rd_mux = cap_r;
            ADDR_FLAG_HOST:  rd_mux = flag_r[host_base +: NLANE];
            ADDR_FLAG_MEDIA: rd_mux = flag_r[media_base +: NLANE];
            ADDR_HOST_EN:    rd_mux = en_r[host_base +: NLANE];
            ADDR_MEDIA_EN:   rd_mux = en_r[media_base +: NLANE];
            ADDR_GATE_CTL:   rd_mux = gc_r[bank_sel_r];
            ADDR_BANK_SEL:   rd_mux = {6'h0, bank_sel_r};
            ADDR_LANE_SEL:   rd_mux = {4'h0, lane_sel_r};
            ADDR_CUR_HI:     rd_mux = sel_cnt.shown[15:8];
            ADDR_CUR_LO:     rd_mux = sel_cnt.shown[7:0];
            ADDR_RES_HI:     rd_mux = sel_cnt.result[15:8];
            ADDR_RES_LO:     rd_mux = sel_cnt.result[7:0];
            default:         rd_mux = 8'h00;
        endcase
    end

    // read data is registered and held until the next read
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_data_r <= 8'h00;
        end else if (REG_RD) begin
            rd_data_r <= rd_mux;
        end
    end

    assign RD_DATA = rd_data_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks across lanes and banks

    a_flag_on_expiry:
        assert property (@(posedge CLK) disable iff (!RST_N)
            lane_done[0] |=> flag_r[0]) else $error("flag not raised");
    a_flag_set_wins:
        assert property (@(posedge CLK) disable iff (!RST_N)
            (lane_done[0] && rd_fhost && bank_sel_r == 2'h0) |=> flag_r[0])
            else $error("flag lost to clear");
    a_bank_local_restart:
        assert property (@(posedge CLK) disable iff (!RST_N)
            (rs_fell[0] && !scope[0] && en_r[0]) |-> lane_clr[0])
            else $error("own bank not restarted");
    a_scoped_restart:
        assert property (@(posedge CLK) disable iff (!RST_N)
            (rs_fell[0] && scope[0] && scope[1] && en_r[3*NLANE]) |-> lane_clr[3*NLANE])
            else $error("scoped bank not restarted");
    a_unscoped_isolated:
        assert property (@(posedge CLK) disable iff (!RST_N)
            (rs_fell[0] && !scope[0] && !rs_fell[1] && !scope[1] && !en_rise[2*NLANE])
            |-> !lane_clr[2*NLANE]) else $error("other bank restarted");
    a_enable_lane_only:
        assert property (@(posedge CLK) disable iff (!RST_N)
            (en_rise[0] && !en_rise[1] && !bank_restart[0]) |-> lane_clr[0] && !lane_clr[1])
            else $error("enable edge leaked");
    a_no_gate_no_done:
        assert property (@(posedge CLK) disable iff (!RST_N)
            (gc_r[0][GC_LEN_LSB +: 3] == 3'h0) [*2] |-> !lane_done[0])
            else $error("expiry with gating off");

    c_restart_cycle:
        cover property (@(posedge CLK) disable iff (!RST_N) rs_set[0] ##[1:20] rs_fell[0]);
    c_scoped_restart:
        cover property (@(posedge CLK) disable iff (!RST_N) any_scoped_fell);
    c_flag_read:
        cover property (@(posedge CLK) disable iff (!RST_N) flag_r[0] ##1 rd_fhost);
endmodule

// [test/pwgt_host.sv]
// host controller model: byte writes and reads on the management register port
// assumes the bench clock; strobes change on the falling edge and last one cycle
module pwgt_host (
    // clock
    input  wire logic       clk,
    // register port
    input  wire logic [7:0] rdata,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle port from time zero
    initial begin
        {addr, wdata, wr, rd} = '0;
    end
    // one-cycle write; restart uses enable toggles or set then clear of the restart bit
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // one-cycle read, data taken once settled; results fetched before next expiry
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
endmodule

// [test/test_pwgt_top.sv]
// bench for the per-lane gate timers: host model on the register port, random lane errors
// assumes one second shortened to 20 cycles; model counts errors of one watched lane
module test_pwgt_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pwgt_pkg::*;
    logic           clk;
    logic           rst_n;
    logic [7:0]     addr, wdata, rdata, v;
    logic           wr, rd;
    logic [NCH-1:0] err_ev;
    logic [31:0]    lfsr;
    int             n_fail = 0;
    int             comparisons = 0;
    int             cyc = 0;
    int             k;
    int             ln = 0;
    ////////////////////////////////////////////////////////////////////////////////
    pwgt_top #(.SEC_CYCLES(20)) i_pwgt_top (.CLK(clk), .RST_N(rst_n), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .RD_DATA(rdata), .ERR_EV(err_ev));
    pwgt_host i_pwgt_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));
    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        i_pwgt_host.get(a, v);
        check(v, exp);
    endtask
    // random pulses on all lanes; the model adds the watched lane's errors while it counts
    task automatic inject(input int n, input bit cnt);
        repeat (2) @(negedge clk);
        repeat (n) begin
            @(negedge clk);
            lfsr = step(lfsr);
            err_ev = {2{lfsr}};
            if (cnt && err_ev[ln])
                k++;
        end
        @(negedge clk);
        err_ev = '0;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        err_ev = '0;
        lfsr = 32'h3696;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        // reset values and an unmapped place
        rc(ADDR_CAP, CAP_RST);
        rc(ADDR_GATE_CTL, GC_RST);
        rc(8'h00, 8'h00);
        // gated without auto restart: counts shown only when the gate ends
        i_pwgt_host.put(ADDR_GATE_CTL, 8'h04);
        i_pwgt_host.put(ADDR_HOST_EN, 8'h01);
        k = 0;
        inject(40, 1);
        rc(ADDR_CUR_LO, 8'h00);
        repeat (80) @(negedge clk);
        rc(ADDR_FLAG_HOST, 8'h01);
        rc(ADDR_FLAG_HOST, 8'h00);
        inject(20, 0);
        rc(ADDR_CUR_HI, 8'h00);
        rc(ADDR_CUR_LO, 8'(k));
        // auto restart: the finished period moves to the result count
        i_pwgt_host.put(ADDR_GATE_CTL, 8'h14);
        i_pwgt_host.put(ADDR_HOST_EN, 8'h00);
        i_pwgt_host.put(ADDR_HOST_EN, 8'h01);
        k = 0;
        inject(40, 1);
        repeat (80) @(negedge clk);
        rc(ADDR_RES_LO, 8'(k));
        rc(ADDR_FLAG_HOST, 8'h01);
        // restart bit freezes the lane, clearing it restarts the current bank
        i_pwgt_host.put(ADDR_GATE_CTL, 8'h24);
        inject(10, 0);
        i_pwgt_host.put(ADDR_GATE_CTL, 8'h04);
        k = 0;
        inject(40, 1);
        repeat (80) @(negedge clk);
        rc(ADDR_CUR_LO, 8'(k));
        // real-time counts refreshed every second during a long gate
        i_pwgt_host.put(ADDR_CAP, 8'h1C);
        rc(ADDR_CAP, 8'h1C);
        i_pwgt_host.put(ADDR_GATE_CTL, 8'h06);
        i_pwgt_host.put(ADDR_HOST_EN, 8'h00);
        i_pwgt_host.put(ADDR_HOST_EN, 8'h01);
        k = 0;
        inject(40, 1);
        repeat (30) @(negedge clk);
        rc(ADDR_CUR_LO, 8'(k));
        // scoped clear in bank 0 restarts a media lane of scoped bank 1
        i_pwgt_host.put(ADDR_BANK_SEL, 8'h01);
        i_pwgt_host.put(ADDR_GATE_CTL, 8'h84);
        i_pwgt_host.put(ADDR_LANE_SEL, 8'h08);
        i_pwgt_host.put(ADDR_MEDIA_EN, 8'h01);
        k = 0;
        ln = 3 * NLANE;
        inject(40, 1);
        repeat (30) @(negedge clk);
        rc(ADDR_CUR_LO, 8'(k));
        i_pwgt_host.put(ADDR_BANK_SEL, 8'h00);
        i_pwgt_host.put(ADDR_GATE_CTL, 8'hA6);
        i_pwgt_host.put(ADDR_GATE_CTL, 8'h86);
        i_pwgt_host.put(ADDR_BANK_SEL, 8'h01);
        rc(ADDR_CUR_LO, 8'h00);
        repeat (110) @(negedge clk);
        rc(ADDR_FLAG_MEDIA, 8'h01);
        report_and_stop();
    end
endmodule
